// ===== dv/sld_panel_model.sv
// Behavioural glass panel: which pixels of the first common look dark
`timescale 1ns/1ps
module sld_panel_model (
  input  wire sld_pkg::sld_com_t com_drive,
  input  wire sld_pkg::sld_seg_t seg_drive,
  output logic [23:0]            dark0
);
  // Only a full swing across a pixel darkens it; a bias step stays clear
  always_comb begin
    for (int s = 0; s < 24; s++) begin
      dark0[s] = com_drive.oe[0] && seg_drive.oe[s] &&
                 ({com_drive.lvl[0], seg_drive.lvl[s]} inside {4'h3, 4'hc});
    end
  end
endmodule

// ===== dv/test_sld_driver.sv
// Self-checking bench for the segment display driver
`timescale 1ns/1ps
module test_sld_driver;
  import sld_pkg::*;
  logic         clk_sys;
  logic         arst_n;
  sld_bus_req_t bus_req;
  logic [7:0]   rd_data;
  logic         sleep_mode;
  logic         sec_osc_tick;
  logic         lf_osc_tick;
  sld_com_t     com_drive;
  sld_seg_t     seg_drive;
  logic         irq;
  logic [23:0]  dark0;
  logic [7:0]   v;
  int           num_errors;
  int           checked;
  int           n;
  int           h;

  sld_driver i_dut (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .bus_req      (bus_req),
    .rd_data      (rd_data),
    .sleep_mode   (sleep_mode),
    .sec_osc_tick (sec_osc_tick),
    .lf_osc_tick  (lf_osc_tick),
    .com_drive    (com_drive),
    .seg_drive    (seg_drive),
    .irq          (irq)
  );

  sld_panel_model i_panel (
    .com_drive (com_drive),
    .seg_drive (seg_drive),
    .dark0     (dark0)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic tick(logic lf);
    @(posedge clk_sys);
    if (lf) begin
      lf_osc_tick <= 1'b1;
    end else begin
      sec_osc_tick <= 1'b1;
    end
    @(posedge clk_sys);
    lf_osc_tick <= 1'b0;
    sec_osc_tick <= 1'b0;
    cyc(3);
  endtask

  // Phase only moves on a tick, so the flag holds until the next access
  task automatic wait_wa(logic want);
    for (int k = 0; k < 8; k++) begin
      rd(ADR_PHASE, v);
      if (v[PH_WA] === want) return;
      tick(1'b0);
    end
    num_errors++;
    results();
  endtask

  initial begin
    arst_n = 1'b0;
    bus_req = '0;
    sleep_mode = 1'b0;
    sec_osc_tick = 1'b0;
    lf_osc_tick = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ADR_CTRL, v);
    chk("ctrl reset", 8'h03, v);
    rd(ADR_PHASE, v);
    chk("phase reset", 8'h13, v);
    rd(6'h3f, v);
    chk("unmapped", 8'h00, v);
    chk("com off", 4'h0, com_drive.oe);
    $display("Test reset done");

    wr(ADR_SEGEN, 8'hff);
    wr(ADR_DATA, 8'h05);
    wr(ADR_PHASE, 8'h00);
    wr(ADR_CTRL, 8'h84);
    cyc(3);
    rd(ADR_PHASE, v);
    chk("active", 1, v[PH_ACTIVE]);
    tick(1'b0);
    chk("static com oe", 4'h1, com_drive.oe);
    chk("seg oe", 24'hff, seg_drive.oe);
    chk("dark", 24'h5, dark0);
    v = com_drive.lvl[0];
    tick(1'b0);
    chk("com invert", v[1:0] ^ 2'h3, com_drive.lvl[0]);
    chk("dark inverted", 24'h5, dark0);
    $display("Test static drive done");

    wait_wa(1'b0);
    wr(ADR_DATA, 8'hff);
    rd(ADR_CTRL, v);
    chk("write_fail_error set", 8'ha4, v);
    chk("write dropped", 24'h5, dark0);
    wr(ADR_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq high", 1, irq);
    rd(ADR_IRQ_STAT, v);
    chk("stat write_fail_error", 1, v[IRQ_WRITE_FAIL_ERROR]);
    rd(ADR_IRQ_STAT, v);
    chk("stat cleared", 0, v[IRQ_WRITE_FAIL_ERROR]);
    cyc(2);
    chk("irq low", 0, irq);
    wr(ADR_CTRL, 8'h84);
    rd(ADR_CTRL, v);
    chk("write_fail_error cleared", 8'h84, v);
    wait_wa(1'b1);
    wr(ADR_DATA, 8'h01);
    cyc(2);
    chk("write taken", 24'h1, dark0);
    $display("Test write fail done");

    wr(ADR_CTRL, 8'hc4);
    @(posedge clk_sys);
    sleep_mode <= 1'b1;
    cyc(3);
    rd(ADR_PHASE, v);
    chk("sleep halt", 0, v[PH_ACTIVE]);
    chk("sleep com off", 4'h0, com_drive.oe);
    wr(ADR_CTRL, 8'h84);
    cyc(3);
    rd(ADR_PHASE, v);
    chk("sleep run", 1, v[PH_ACTIVE]);
    @(posedge clk_sys);
    sleep_mode <= 1'b0;
    $display("Test sleep done");

    for (int m = 0; m < 4; m++) begin
      wr(ADR_CTRL, 8'h84 | m[7:0]);
      cyc(3);
      tick(1'b0);
      chk("com count", (1 << (m + 1)) - 1, com_drive.oe);
    end
    for (int b = 0; b < 2; b++) begin
      wr(ADR_PHASE, b ? 8'h40 : 8'h00);
      wr(ADR_CTRL, 8'h85);
      h = 0;
      for (int k = 0; k < 2; k++) begin
        tick(1'b0);
        h += (com_drive.lvl[0] === LV1 || com_drive.lvl[1] === LV1);
      end
      chk("bias mid level", b ? 2 : 1, h);
    end
    wr(ADR_PHASE, 8'h00);
    $display("Test multiplex done");

    wr(ADR_CTRL, 8'h88);
    cyc(3);
    v = com_drive.lvl[0];
    tick(1'b1);
    chk("lf step", v[1:0] ^ 2'h3, com_drive.lvl[0]);
    v = com_drive.lvl[0];
    tick(1'b0);
    chk("sec ignored", v[1:0], com_drive.lvl[0]);
    wr(ADR_PHASE, 8'h01);
    wr(ADR_CTRL, 8'h80);
    v = com_drive.lvl[0];
    for (n = 0; n < 3000 && com_drive.lvl[0] === v[1:0]; n++) cyc(1);
    v = com_drive.lvl[0];
    for (n = 0; n < 3000 && com_drive.lvl[0] === v[1:0]; n++) cyc(1);
    chk("fosc step", 512, n);
    $display("Test clock source done");

    // Type-B: common 0 goes unselected before its polarity flips
    wr(ADR_PHASE, 8'h80);
    wr(ADR_CTRL, 8'h05);
    wr(ADR_CTRL, 8'h85);
    cyc(3);
    chk("typeb start", LV3, com_drive.lvl[0]);
    tick(1'b0);
    chk("typeb same pol", LV1, com_drive.lvl[0]);
    tick(1'b0);
    chk("typeb frame flip", LV0, com_drive.lvl[0]);
    wr(ADR_PHASE, 8'h00);
    $display("Test type-B done");

    wr(ADR_CTRL, 8'h04);
    cyc(3);
    rd(ADR_PHASE, v);
    chk("off active", 0, v[PH_ACTIVE]);
    chk("off com", 4'h0, com_drive.oe);
    chk("off seg", 24'h0, seg_drive.oe);
    $display("Test disable done");
    results();
  end
endmodule

// ===== rtl/sld_driver.sv
// Segment display driver: registers, clock select, prescaler, drive timing
`timescale 1ns/1ps
// Overview of operation
// - Drives up to four commons and 24 segments; 16-segment variant too.
// - Driver runs only while display_driver_enable (control bit 7) is one.
// - sleep_halt_select (bit 6) one halts the driver during sleep.
// - Pixel write while write_allowed_flag is zero sets write_fail_error.
// - Clock source: 00 system clock/256, 01 secondary oscillator, 1x LF osc.
// - common_count_select picks 1..4 commons; resets to four commons.
// - Two or three commons: bias bit one gives half, zero third.
// - waveform_type one inverts per frame, zero within each common period.
// - Phase bit 5 reads one while the driver is active.
// - Phase bit 4 reads one while pixel writes are permitted.
// - prescale_select divides the selected clock by value plus one.
// - A pixel bit of one drives dark, zero leaves clear.
// - Pixel register 3*common+group holds that common's segments.
// - Segment enable registers 0..2 enable segments 7..0, 15..8, 23..16.
// - On 16 segments, segment 15 is lost in four-common mode.
module sld_driver #(
  parameter int NUM_SEG = 24
) (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire sld_pkg::sld_bus_req_t bus_req,
  output logic [7:0]                rd_data,
  input  wire logic                 sleep_mode,
  input  wire logic                 sec_osc_tick,
  input  wire logic                 lf_osc_tick,
  output sld_pkg::sld_com_t         com_drive,
  output sld_pkg::sld_seg_t         seg_drive,
  output logic                      irq
);
  import sld_pkg::*;

  localparam int NGRP = NUM_SEG / 8;

  sld_state_t s;
  sld_state_t next_s;

  // Common drive level for a selected or idle common
  function automatic logic [1:0] com_level(input logic [1:0] kind,
                                           input logic       sel,
                                           input logic       pol);
    logic [1:0] v;
    v = pol ? LV0 : LV3;
    if (!sel) begin
      if (kind == BIAS_THIRD) begin
        v = pol ? LV2 : LV1;
      end else begin
        v = LV1;
      end
    end
    return v;
  endfunction

  // Segment drive level; dark opposes the selected common
  function automatic logic [1:0] seg_level(input logic [1:0] kind,
                                           input logic       dark,
                                           input logic       pol);
    logic [1:0] v;
    v = pol ? LV3 : LV0;
    if (!dark) begin
      if (kind == BIAS_THIRD) begin
        v = pol ? LV1 : LV2;
      end else begin
        v = pol ? LV0 : LV3;
      end
    end
    return v;
  endfunction

  logic       src_tick;
  logic       step;
  logic       last_com;
  logic       frame_end;
  logic       wa;
  logic       halt_req;
  logic [1:0] bias_kind;
  logic       data_wr;

  always_comb begin
    // Selected clock source, then the prescaler
    case (s.cs)
      CS_FOSC: src_tick = (s.div256 == FOSC_DIV_MAX);
      CS_SEC:  src_tick = sec_osc_tick;
      default: src_tick = lf_osc_tick;
    endcase
    step      = (s.st == SLD_RUN) && src_tick && (s.pcnt == s.lp);
    last_com  = (s.com_idx == s.mux);
    frame_end = last_com && (s.waveform_type || s.pol);
    // Pixels are frozen in the last phase of a frame
    wa        = (s.st != SLD_RUN) || !frame_end;
    halt_req  = sleep_mode && s.slp;
    if (s.mux == 2'h0) begin
      bias_kind = BIAS_STATIC;
    end else if (s.bias && s.mux != 2'h3) begin
      bias_kind = BIAS_HALF;
    end else begin
      bias_kind = BIAS_THIRD;
    end
    data_wr = bus_req.wr && bus_req.addr >= ADR_DATA &&
              bus_req.addr < ADR_DATA + 6'(3 * 4);
  end

  always_comb begin
    next_s = s;
    // Driver state
    case (s.st)
      SLD_IDLE: begin
        if (s.en && !halt_req) begin
          next_s.st = SLD_RUN;
        end
      end
      SLD_RUN: begin
        if (!s.en) begin
          next_s.st = SLD_IDLE;
        end else if (halt_req) begin
          next_s.st = SLD_HALT;
        end
      end
      SLD_HALT: begin
        if (!s.en) begin
          next_s.st = SLD_IDLE;
        end else if (!halt_req) begin
          next_s.st = SLD_RUN;
        end
      end
      default: next_s.st = SLD_IDLE;
    endcase
    if (!s.en || halt_req) begin
      next_s.st = (!s.en) ? SLD_IDLE : SLD_HALT;
    end

    // Timebase
    next_s.div256 = s.div256 + 8'h01;
    if (s.st != SLD_RUN) begin
      next_s.pcnt    = 4'h0;
      next_s.com_idx = 2'h0;
      next_s.pol     = 1'b0;
    end else if (src_tick) begin
      next_s.pcnt = (s.pcnt == s.lp) ? 4'h0 : s.pcnt + 4'h1;
    end
    if (step) begin
      if (s.waveform_type) begin
        // Type-B: all commons in one polarity, flip at the frame edge
        next_s.com_idx = last_com ? 2'h0 : s.com_idx + 2'h1;
        next_s.pol     = last_com ? !s.pol : s.pol;
      end else begin
        // Type-A: both polarities inside each common period
        next_s.pol = !s.pol;
        if (s.pol) begin
          next_s.com_idx = last_com ? 2'h0 : s.com_idx + 2'h1;
        end
      end
    end

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADR_CTRL: begin
          next_s.en  = bus_req.wdata[CTRL_EN];
          next_s.slp = bus_req.wdata[CTRL_SLP];
          // Write-one has no effect; only software clears it
          if (!bus_req.wdata[CTRL_WRITE_FAIL_ERROR]) begin
            next_s.write_fail_error = 1'b0;
          end
          next_s.cs  = bus_req.wdata[CTRL_CS_LO +: 2];
          next_s.mux = bus_req.wdata[CTRL_MUX_LO +: 2];
        end
        ADR_PHASE: begin
          next_s.waveform_type  = bus_req.wdata[PH_WFT];
          next_s.bias = bus_req.wdata[PH_BIAS];
          next_s.lp   = bus_req.wdata[PH_LP_LO +: 4];
        end
        ADR_IRQ_MASK: next_s.irq_mask = bus_req.wdata[1:0];
        default: ;
      endcase
      for (int g = 0; g < NGRP; g++) begin
        if (bus_req.addr == ADR_SEGEN + 6'(g)) begin
          next_s.seg_en[g*8 +: 8] = bus_req.wdata;
        end
      end
      for (int c = 0; c < 4; c++) begin
        for (int g = 0; g < NGRP; g++) begin
          if (wa && bus_req.addr == ADR_DATA + 6'(3 * c + g)) begin
            next_s.pix[c][g*8 +: 8] = bus_req.wdata;
          end
        end
      end
    end

    // Read data and read-to-clear interrupt status
    next_s.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADR_CTRL:     next_s.rdata = {s.en, s.slp, s.write_fail_error, 1'b0, s.cs,
                                      s.mux};
        ADR_PHASE:    next_s.rdata = {s.waveform_type, s.bias, s.st == SLD_RUN,
                                      wa, s.lp};
        ADR_IRQ_STAT: begin
          next_s.rdata    = {6'h00, s.irq_stat};
          next_s.irq_stat = 2'h0;
        end
        ADR_IRQ_MASK: next_s.rdata = {6'h00, s.irq_mask};
        default: ;
      endcase
      for (int g = 0; g < NGRP; g++) begin
        if (bus_req.addr == ADR_SEGEN + 6'(g)) begin
          next_s.rdata = s.seg_en[g*8 +: 8];
        end
      end
      for (int c = 0; c < 4; c++) begin
        for (int g = 0; g < NGRP; g++) begin
          if (bus_req.addr == ADR_DATA + 6'(3 * c + g)) begin
            next_s.rdata = s.pix[c][g*8 +: 8];
          end
        end
      end
    end

    // Events win over a clear in the same cycle
    if (data_wr && !wa) begin
      next_s.write_fail_error               = 1'b1;
      next_s.irq_stat[IRQ_WRITE_FAIL_ERROR] = 1'b1;
    end
    if (step && frame_end) begin
      next_s.irq_stat[IRQ_FRAME] = 1'b1;
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

    // Panel drive, inactive whenever the driver is not running
    next_s.common_line = '0;
    next_s.segment_line = '0;
    if (s.st == SLD_RUN) begin
      for (int c = 0; c < 4; c++) begin
        if (2'(c) <= s.mux) begin
          next_s.common_line.oe[c]  = 1'b1;
          next_s.common_line.lvl[c] = com_level(bias_kind, 2'(c) == s.com_idx,
                                        s.pol);
        end
      end
      for (int k = 0; k < NUM_SEG; k++) begin
        next_s.segment_line.oe[k]  = s.seg_en[k];
        next_s.segment_line.lvl[k] = seg_level(bias_kind, s.pix[s.com_idx][k],
                                      s.pol);
      end
      if (NUM_SEG == 16 && s.mux == 2'h3) begin
        next_s.segment_line.oe[15]  = 1'b0;
        next_s.segment_line.lvl[15] = LV0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s     <= '0;
      s.st  <= SLD_IDLE;
      s.mux <= MUX_RST;
      s.lp  <= LP_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data   = s.rdata;
  assign com_drive = s.common_line;
  assign seg_drive = s.segment_line;
  assign irq       = s.irq;

  // Checks
  sequence blocked_wr_s;
    data_wr && !wa;
  endsequence

  write_fail_error_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    blocked_wr_s |=> s.write_fail_error && s.irq_stat[IRQ_WRITE_FAIL_ERROR])
    else $error("blocked pixel write did not flag an error");

  blocked_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    blocked_wr_s |=> $stable(s.pix))
    else $error("blocked pixel write changed pixel data");

  enable_run_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !s.en |=> s.st != SLD_RUN)
    else $error("driver running while disabled");

  sleep_halt_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s.en && sleep_mode && s.slp |=> s.st == SLD_HALT)
    else $error("driver not halted in sleep");

  outputs_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s.st != SLD_RUN |=> com_drive.oe == 4'h0 && seg_drive.oe == 24'h0)
    else $error("outputs driven while driver stopped");

  common_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s.st == SLD_RUN |=> com_drive.oe == 4'((5'h2 << $past(s.mux)) - 5'h1))
    else $error("wrong number of commons driven");

  prescale_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    step |=> s.pcnt == 4'h0)
    else $error("phase step off the prescaler count");

  fosc_div_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    step && s.cs == CS_FOSC |-> s.div256 == FOSC_DIV_MAX)
    else $error("system clock source not divided by 256");

  seg_share_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    NUM_SEG == 16 && s.mux == 2'h3 |=> !seg_drive.oe[15])
    else $error("shared segment driven with four commons");

  active_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    bus_req.rd && bus_req.addr == ADR_PHASE |=>
      rd_data[PH_ACTIVE] == ($past(s.st) == SLD_RUN) &&
      rd_data[PH_WA] == $past(wa))
    else $error("phase status bits misreported");

  typeb_pol_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    step && s.waveform_type && !last_com |=> $stable(s.pol))
    else $error("type-B polarity changed inside a frame");
endmodule

// ===== rtl/sld_pkg.sv
// Package with register map, field layouts and types of the segment driver
package sld_pkg;
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  ADR_CTRL     = 6'h00;
  localparam logic [5:0]  ADR_PHASE    = 6'h01;
  localparam logic [5:0]  ADR_SEGEN    = 6'h04;
  localparam logic [5:0]  ADR_IRQ_STAT = 6'h08;
  localparam logic [5:0]  ADR_IRQ_MASK = 6'h09;
  localparam logic [5:0]  ADR_DATA     = 6'h10;
  // Control register fields
  localparam int          CTRL_EN      = 7;
  localparam int          CTRL_SLP     = 6;
  localparam int          CTRL_WRITE_FAIL_ERROR    = 5;
  localparam int          CTRL_CS_LO   = 2;
  localparam int          CTRL_MUX_LO  = 0;
  // Phase register fields
  localparam int          PH_WFT       = 7;
  localparam int          PH_BIAS      = 6;
  localparam int          PH_ACTIVE    = 5;
  localparam int          PH_WA        = 4;
  localparam int          PH_LP_LO     = 0;
  // Interrupt status bits
  localparam int          IRQ_WRITE_FAIL_ERROR     = 0;
  localparam int          IRQ_FRAME    = 1;
  // Reset values, clock source codes and system clock divider end count
  localparam logic [1:0]  MUX_RST      = 2'h3;
  localparam logic [3:0]  LP_RST       = 4'h3;
  localparam logic [1:0]  CS_FOSC      = 2'h0;
  localparam logic [1:0]  CS_SEC       = 2'h1;
  localparam logic [7:0]  FOSC_DIV_MAX = 8'hff;
  // Drive level codes, V0 lowest, V3 highest, then bias kind codes
  localparam logic [1:0]  LV0          = 2'h0;
  localparam logic [1:0]  LV1          = 2'h1;
  localparam logic [1:0]  LV2          = 2'h2;
  localparam logic [1:0]  LV3          = 2'h3;
  localparam logic [1:0]  BIAS_STATIC  = 2'h0;
  localparam logic [1:0]  BIAS_HALF    = 2'h1;
  localparam logic [1:0]  BIAS_THIRD   = 2'h2;

  typedef enum logic [1:0] {
    SLD_IDLE = 2'b00,
    SLD_RUN  = 2'b01,
    SLD_HALT = 2'b11
  } sld_st_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sld_bus_req_t;

  typedef struct packed {
    logic [3:0][1:0] lvl;
    logic [3:0]      oe;
  } sld_com_t;

  typedef struct packed {
    logic [23:0][1:0] lvl;
    logic [23:0]      oe;
  } sld_seg_t;

  typedef struct packed {
    sld_st_t          st;
    logic             en;
    logic             slp;
    logic             write_fail_error;
    logic [1:0]       cs;
    logic [1:0]       mux;
    logic             waveform_type;
    logic             bias;
    logic [3:0]       lp;
    logic [23:0]      seg_en;
    logic [3:0][23:0] pix;
    logic [7:0]       div256;
    logic [3:0]       pcnt;
    logic [1:0]       com_idx;
    logic             pol;
    logic [1:0]       irq_stat;
    logic [1:0]       irq_mask;
    logic             irq;
    logic [7:0]       rdata;
    sld_com_t         common_line;
    sld_seg_t         segment_line;
  } sld_state_t;
endpackage
